// file: rtl/dcbsp_pkg.sv
/*
  Shared constants of the burst-of-two common-I/O SRAM port: widths, DLL lock
  count, host clock division and read latency figures.
  Assumes the host runs on a 25 MHz reference clock and divides it for K.
*/
package dcbsp_pkg;
  // Organisation
  localparam int ADDR_W = 19;
  localparam int DATA_W = 36;
  localparam int BYTE_W = 9;
  // DLL lock time in K cycles
  localparam int DLL_LOCK_CYCLES = 2048;
  // Host clocking
  localparam int REF_CLK_MHZ = 25;
  localparam int K_DIV = 4;
  localparam int BYPASS_MAX_MHZ = 167;
  localparam logic [1:0] PH_CMD = 2'h2;
  // Ref cycles from command launch to first read beat on the pins
  localparam logic [4:0] LAT_BYP_T = 5'h05;
  localparam logic [4:0] LAT_DLL_T = 5'h0b;
  // Host write beat schedule, ref cycles after command launch; the read gap counts from the first read beat
  localparam logic [4:0] T_LD_OFF = 5'h02;
  localparam logic [4:0] T_BEAT0 = 5'h04;
  localparam logic [4:0] T_BEAT1 = 5'h06;
  localparam logic [4:0] T_WR_END = 5'h08;
  localparam logic [4:0] T_RD_GAP = 5'h09;
endpackage

// file: rtl/dcbsp_link_if.sv
/*
  Pin bundle between the SRAM device end and the host controller end.
  Assumes the bench joins both modports; the shared data bus is resolved here
  from the two output enables.
*/
`timescale 1ns/10ps
interface dcbsp_link_if #(
  parameter int ADDR_W = dcbsp_pkg::ADDR_W,
  parameter int DATA_W = dcbsp_pkg::DATA_W
);
  localparam int NBW = DATA_W / dcbsp_pkg::BYTE_W;
  logic k;
  logic k_n;
  logic load_n;
  logic rw_sel;
  logic [ADDR_W-1:0] addr_in;
  logic [NBW-1:0] byte_write_n;
  logic [DATA_W-1:0] dq_h;
  logic dq_h_oe;
  logic [DATA_W-1:0] dq_d;
  logic dq_d_oe;
  logic [DATA_W-1:0] dq;
  logic echo_ref_pos;
  logic echo_ref_neg;
  logic read_valid_flag;
  logic dll_off_n;

  // Shared bus level from the enables; an idle bus shows the inverse of the
  // last device word, so a sample taken outside a drive window reads garbage
  assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : ~dq_d);

  modport dev (
    input k, k_n, load_n, rw_sel, addr_in, byte_write_n, dq, dll_off_n,
    output dq_d, dq_d_oe, echo_ref_pos, echo_ref_neg, read_valid_flag
  );
  modport host (
    output k, k_n, load_n, rw_sel, addr_in, byte_write_n, dq_h, dq_h_oe, dll_off_n,
    input dq, echo_ref_pos, echo_ref_neg, read_valid_flag
  );
endinterface

// file: rtl/dcbsp_dev.sv
/*
  Device end of the burst-of-two common-I/O DDR SRAM: command capture on K,
  write beats on K and K#, late-write buffers, memory array, read pipeline
  with DLL or bypass latency, echo clocks and read-valid flag.
  Assumes the link modport is driven by a host that keeps K# inverted to K.
*/
`timescale 1ns/10ps
module dcbsp_dev #(
  parameter int ADDR_W = dcbsp_pkg::ADDR_W,
  parameter int DATA_W = dcbsp_pkg::DATA_W,
  parameter int LOCK_CYCLES = dcbsp_pkg::DLL_LOCK_CYCLES
) (
  dcbsp_link_if.dev link,
  input wire logic i_rst_n,
  output logic o_dll_locked
);
  localparam int BW = dcbsp_pkg::BYTE_W;
  localparam int NBW = DATA_W / BW;
  localparam int LCW = $clog2(LOCK_CYCLES + 1);

  // Only the two documented organisations
  if (DATA_W != 18 && DATA_W != 36) begin : g_bad_width
    $error("DATA_W must be 18 or 36");
  end
  if (LOCK_CYCLES < 1) begin : g_bad_lock
    $error("LOCK_CYCLES must be positive");
  end

  typedef struct packed {
    logic v;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d0;
    logic [DATA_W-1:0] d1;
    logic [NBW-1:0] be0;
    logic [NBW-1:0] be1;
  } dcbsp_wb_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [LCW-1:0] lock_cnt;
    logic locked;
    logic rd_cmd;
    logic cmd_byp;
    logic [ADDR_W-1:0] rd_addr;
    logic rd1_v;
    logic rd1_byp;
    logic [DATA_W-1:0] rd1_d0;
    logic [DATA_W-1:0] rd1_d1;
    logic rd2_v;
    logic [DATA_W-1:0] rd2_d0;
    logic [DATA_W-1:0] rd2_d1;
    logic wr_cmd;
    logic [ADDR_W-1:0] wr_addr;
    logic pend_v;
    logic [ADDR_W-1:0] pend_a;
    logic [DATA_W-1:0] pend_d0;
    logic [NBW-1:0] pend_be0;
    dcbsp_wb_s wb0;
    dcbsp_wb_s wb1;
    logic echo;
    logic out_oe;
    logic out_vld;
    logic [DATA_W-1:0] out_d;
  } dcbsp_pos_s;

  typedef struct packed {
    logic [DATA_W-1:0] pend_d1;
    logic [NBW-1:0] pend_be1;
    logic echo;
    logic out_oe;
    logic out_vld;
    logic [DATA_W-1:0] out_d;
  } dcbsp_neg_s;

  dcbsp_pos_s r;
  dcbsp_pos_s next_r;
  dcbsp_neg_s q;
  dcbsp_neg_s next_q;
  logic [DATA_W-1:0] mem [0:(2**(ADDR_W+1))-1];
  logic bypass;
  logic byp_rd;
  logic commit;
  logic [DATA_W-1:0] look0;
  logic [DATA_W-1:0] look1;

  // Newer bytes replace older ones where the enable is low
  function automatic logic [DATA_W-1:0] overlay(input logic [DATA_W-1:0] old_w,
                                                input logic [DATA_W-1:0] new_w,
                                                input logic [NBW-1:0] be_n);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < NBW; i++) begin
      if (!be_n[i]) begin
        res[i*BW +: BW] = new_w[i*BW +: BW];
      end
    end
    return res;
  endfunction

  assign bypass = ~r.sync2;
  assign byp_rd = r.rd_cmd & r.cmd_byp;
  assign commit = r.pend_v & r.wb1.v;

  // Read lookup: array, then oldest buffer, newer buffer, pending write
  always_comb begin
    look0 = mem[{r.rd_addr, 1'b0}];
    look1 = mem[{r.rd_addr, 1'b1}];
    if (r.wb1.v && r.wb1.a == r.rd_addr) begin
      look0 = overlay(look0, r.wb1.d0, r.wb1.be0);
      look1 = overlay(look1, r.wb1.d1, r.wb1.be1);
    end
    if (r.wb0.v && r.wb0.a == r.rd_addr) begin
      look0 = overlay(look0, r.wb0.d0, r.wb0.be0);
      look1 = overlay(look1, r.wb0.d1, r.wb0.be1);
    end
    if (r.pend_v && r.pend_a == r.rd_addr) begin
      look0 = overlay(look0, r.pend_d0, r.pend_be0);
      look1 = overlay(look1, q.pend_d1, q.pend_be1);
    end
  end

  // K rising edge logic
  always_comb begin
    next_r = r;
    // Bypass pin, two-flop synchroniser
    next_r.sync1 = link.dll_off_n;
    next_r.sync2 = r.sync1;
    if (bypass) begin
      next_r.lock_cnt = '0;
      next_r.locked = 1'b0;
    end else if (!r.locked) begin
      next_r.lock_cnt = r.lock_cnt + LCW'(1);
      next_r.locked = (r.lock_cnt == LCW'(LOCK_CYCLES - 1));
    end
    // Command capture, only on K rise with load low
    next_r.rd_cmd = ~link.load_n & link.rw_sel;
    next_r.wr_cmd = ~link.load_n & ~link.rw_sel;
    if (!link.load_n) begin
      next_r.cmd_byp = bypass;
      if (link.rw_sel) begin
        next_r.rd_addr = link.addr_in;
      end else begin
        next_r.wr_addr = link.addr_in;
      end
    end
    // Read pipeline: lookup one cycle after command, extra stage with DLL
    next_r.rd1_v = r.rd_cmd;
    next_r.rd1_byp = r.cmd_byp;
    next_r.rd1_d0 = look0;
    next_r.rd1_d1 = look1;
    next_r.rd2_v = r.rd1_v & ~r.rd1_byp;
    next_r.rd2_d0 = r.rd1_d0;
    next_r.rd2_d1 = r.rd1_d1;
    // First write beat with its byte enables, one cycle after command
    next_r.pend_v = r.wr_cmd;
    if (r.wr_cmd) begin
      next_r.pend_a = r.wr_addr;
      next_r.pend_d0 = link.dq;
      next_r.pend_be0 = link.byte_write_n;
    end
    // Completed write enters the buffers, the oldest leaves for the array
    if (r.pend_v) begin
      next_r.wb1 = r.wb0;
      next_r.wb0.v = 1'b1;
      next_r.wb0.a = r.pend_a;
      next_r.wb0.d0 = r.pend_d0;
      next_r.wb0.d1 = q.pend_d1;
      next_r.wb0.be0 = r.pend_be0;
      next_r.wb0.be1 = q.pend_be1;
    end
    // K-rise output slot: bypass beat 0 or DLL beat 1
    next_r.echo = 1'b1;
    next_r.out_oe = byp_rd | r.rd2_v;
    next_r.out_d = byp_rd ? look0 : r.rd2_d1;
    // Flag leads the next K# slot by half a cycle
    next_r.out_vld = byp_rd | (r.rd1_v & ~r.rd1_byp);
  end

  // K# rising edge logic
  always_comb begin
    next_q = q;
    if (r.pend_v) begin
      next_q.pend_d1 = link.dq;
      next_q.pend_be1 = link.byte_write_n;
    end
    // K#-rise output slot: bypass beat 1 or DLL beat 0
    next_q.echo = 1'b0;
    next_q.out_oe = (r.rd1_v & r.rd1_byp) | r.rd2_v;
    next_q.out_d = (r.rd1_v & r.rd1_byp) ? r.rd1_d1 : r.rd2_d0;
    // Flag leads the next K slot by half a cycle
    next_q.out_vld = byp_rd | r.rd2_v;
  end

  always_ff @(posedge link.k or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge link.k_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Array write of the buffer leaving on the third write, byte by byte;
  // one process so the array has a single driver
  always_ff @(posedge link.k) begin
    for (int i = 0; i < NBW; i++) begin
      if (commit && !r.wb1.be0[i]) begin
        mem[{r.wb1.a, 1'b0}][i*BW +: BW] <= r.wb1.d0[i*BW +: BW];
      end
      if (commit && !r.wb1.be1[i]) begin
        mem[{r.wb1.a, 1'b1}][i*BW +: BW] <= r.wb1.d1[i*BW +: BW];
      end
    end
  end

  // Double-rate pin mux: K high shows the K slot, K low the K# slot
  assign link.dq_d = link.k ? r.out_d : q.out_d;
  assign link.dq_d_oe = link.k ? r.out_oe : q.out_oe;
  assign link.echo_ref_pos = link.k ? r.echo : q.echo;
  assign link.echo_ref_neg = link.k ? ~r.echo : ~q.echo;
  assign link.read_valid_flag = link.k ? r.out_vld : q.out_vld;
  assign o_dll_locked = r.locked;
endmodule

// file: rtl/dcbsp_host.sv
/*
  Host controller end: divides the reference clock into K and K#, issues one
  burst-of-two read or write at a time, drives late-write beats and collects
  read beats at the latency of the current DLL mode.
  Assumes a user that holds a request until it sees o_req_ready.
*/
`timescale 1ns/10ps
module dcbsp_host #(
  parameter int ADDR_W = dcbsp_pkg::ADDR_W,
  parameter int DATA_W = dcbsp_pkg::DATA_W,
  parameter int LOCK_CYCLES = dcbsp_pkg::DLL_LOCK_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_dll_enable,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [DATA_W-1:0] i_req_data0,
  input wire logic [DATA_W-1:0] i_req_data1,
  input wire logic [DATA_W/dcbsp_pkg::BYTE_W-1:0] i_req_be_n0,
  input wire logic [DATA_W/dcbsp_pkg::BYTE_W-1:0] i_req_be_n1,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data0,
  output logic [DATA_W-1:0] o_rd_data1,
  output logic o_dll_ready,
  dcbsp_link_if.host link
);
  localparam int NBW = DATA_W / dcbsp_pkg::BYTE_W;
  localparam int LCW = $clog2(LOCK_CYCLES + 1);

  // Bypass mode limits K frequency
  if (dcbsp_pkg::REF_CLK_MHZ / dcbsp_pkg::K_DIV > dcbsp_pkg::BYPASS_MAX_MHZ) begin : g_bad_k
    $error("K too fast for DLL bypass mode");
  end
  if (DATA_W != 18 && DATA_W != 36) begin : g_bad_width
    $error("DATA_W must be 18 or 36");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD} dcbsp_st_e;

  typedef struct packed {
    logic [1:0] ph;
    logic k;
    logic k_n;
    dcbsp_st_e st;
    logic [4:0] t;
    logic [4:0] lat;
    logic load_n;
    logic rw_sel;
    logic [ADDR_W-1:0] addr;
    logic [NBW-1:0] bw_n;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic dll_off_n;
    logic [LCW-1:0] lock_cnt;
    logic dll_rdy;
    logic ready;
    logic [DATA_W-1:0] d0;
    logic [DATA_W-1:0] d1;
    logic [NBW-1:0] be0;
    logic [NBW-1:0] be1;
    logic rd_v;
    logic [DATA_W-1:0] rd0;
    logic [DATA_W-1:0] rd1;
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
  } dcbsp_host_s;

  dcbsp_host_s r;
  dcbsp_host_s next_r;
  logic [1:0] nph;
  logic [4:0] nt;

  assign nph = r.ph + 2'h1;
  assign nt = r.t + 5'h01;

  always_comb begin
    next_r = r;
    // K high for phases 0 and 1; K# its inverse
    next_r.ph = nph;
    next_r.k = (nph == 2'h0) || (nph == 2'h1);
    next_r.k_n = ~((nph == 2'h0) || (nph == 2'h1));
    // Read bus, two flops before use
    next_r.s1 = link.dq;
    next_r.s2 = r.s1;
    next_r.rd_v = 1'b0;
    // DLL enable and lock wait
    next_r.dll_off_n = i_dll_enable;
    if (!r.dll_off_n) begin
      next_r.lock_cnt = '0;
      next_r.dll_rdy = 1'b0;
    end else if (!r.dll_rdy && nph == 2'h0) begin
      next_r.lock_cnt = r.lock_cnt + LCW'(1);
      next_r.dll_rdy = (r.lock_cnt == LCW'(LOCK_CYCLES - 1));
    end
    case (r.st)
      ST_IDLE: begin
        // Launch command a quarter K cycle (one ref cycle) before the K rise
        if (r.ready && i_req_valid) begin
          next_r.load_n = 1'b0;
          next_r.rw_sel = ~i_req_write;
          next_r.addr = i_req_addr;
          next_r.d0 = i_req_data0;
          next_r.d1 = i_req_data1;
          next_r.be0 = i_req_be_n0;
          next_r.be1 = i_req_be_n1;
          next_r.t = 5'h00;
          next_r.lat = r.dll_off_n ? dcbsp_pkg::LAT_DLL_T : dcbsp_pkg::LAT_BYP_T;
          next_r.st = i_req_write ? ST_WR : ST_RD;
        end
      end
      ST_WR: begin
        next_r.t = nt;
        if (nt == dcbsp_pkg::T_LD_OFF) begin
          next_r.load_n = 1'b1;
          next_r.rw_sel = 1'b1;
        end
        if (nt == dcbsp_pkg::T_BEAT0) begin
          next_r.dq_oe = 1'b1;
          next_r.dq = r.d0;
          next_r.bw_n = r.be0;
        end
        if (nt == dcbsp_pkg::T_BEAT1) begin
          next_r.dq = r.d1;
          next_r.bw_n = r.be1;
        end
        if (nt == dcbsp_pkg::T_WR_END) begin
          next_r.dq_oe = 1'b0;
          next_r.bw_n = '1;
          next_r.st = ST_IDLE;
        end
      end
      ST_RD: begin
        next_r.t = nt;
        if (nt == dcbsp_pkg::T_LD_OFF) begin
          next_r.load_n = 1'b1;
        end
        // Beat reaches s2 two ref edges after the device drives it, taken on the third
        if (nt == r.lat + 5'h03) begin
          next_r.rd0 = r.s2;
        end
        if (nt == r.lat + 5'h05) begin
          next_r.rd1 = r.s2;
          next_r.rd_v = 1'b1;
        end
        // Bus left idle a full K cycle past the last beat
        if (nt == r.lat + dcbsp_pkg::T_RD_GAP) begin
          next_r.st = ST_IDLE;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
    next_r.ready = (next_r.st == ST_IDLE) && (nph == dcbsp_pkg::PH_CMD) &&
                   (!r.dll_off_n || r.dll_rdy);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
      r.ph <= 2'h3; // First K high lasts a full half period
      r.load_n <= 1'b1;
      r.rw_sel <= 1'b1;
      r.bw_n <= '1;
      r.k_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.k = r.k;
  assign link.k_n = r.k_n;
  assign link.load_n = r.load_n;
  assign link.rw_sel = r.rw_sel;
  assign link.addr_in = r.addr;
  assign link.byte_write_n = r.bw_n;
  assign link.dq_h = r.dq;
  assign link.dq_h_oe = r.dq_oe;
  assign link.dll_off_n = r.dll_off_n;
  assign o_req_ready = r.ready;
  assign o_rd_valid = r.rd_v;
  assign o_rd_data0 = r.rd0;
  assign o_rd_data1 = r.rd1;
  assign o_dll_ready = r.dll_rdy;
endmodule

// file: testbench/dcbsp_link_sva.sv
/*
  Checker on the pins between the SRAM device end and the host end.
  Assumes the bench instantiates it beside the link, clocked by the host reference clock.
*/
`timescale 1ns/10ps
module dcbsp_link_sva (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic load_n,
  input wire logic rw_sel,
  input wire logic dq_d_oe,
  input wire logic dq_h_oe,
  input wire logic echo_ref_pos,
  input wire logic echo_ref_neg,
  input wire logic read_valid_flag,
  input wire logic dll_off_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Input clock pair
  a_clk_inverse: assert property (k_n == !k) else $error("k_n not inverse of k");
  a_k_period: assert property ($rose(k) |-> ##4 $rose(k)) else $error("k stopped");
  // Echo clocks
  a_echo_pair: assert property (echo_ref_neg != echo_ref_pos) else $error("echo pair equal");
  a_echo_run: assert property ($rose(echo_ref_pos) |-> ##4 $rose(echo_ref_pos))
    else $error("echo clock stopped");
  // Data bus ownership
  a_bus_excl: assert property (!(dq_d_oe && dq_h_oe)) else $error("bus driven twice");
  a_oe_window: assert property ($rose(dq_d_oe) |-> dq_d_oe [*4] ##1 !dq_d_oe)
    else $error("device drive length");
  // Read-valid flag
  a_flag_lead: assert property ($rose(read_valid_flag) |-> ##2 $rose(dq_d_oe))
    else $error("flag not ahead of data");
  a_flag_len: assert property ($rose(read_valid_flag) |-> read_valid_flag [*4] ##1 !read_valid_flag)
    else $error("flag length");
  // Read latency per mode
  a_lat_bypass: assert property (($fell(load_n) && rw_sel && !dll_off_n && !$past(dll_off_n, 8))
    |-> ##5 $rose(dq_d_oe)) else $error("bypass read latency");
  a_lat_dll: assert property (($fell(load_n) && rw_sel && dll_off_n && $past(dll_off_n, 8))
    |-> ##11 $rose(dq_d_oe)) else $error("dll read latency");
  // Host command and write beats
  a_load_pulse: assert property ($fell(load_n) |-> ##1 !load_n ##1 load_n)
    else $error("load width");
  a_wr_beats: assert property (($fell(load_n) && !rw_sel) |-> ##4 dq_h_oe [*4] ##1 !dq_h_oe)
    else $error("write beat timing");
endmodule

// file: testbench/ddr_cio_burst2_sram_port_bench.sv
/*
  Bench joining the host end and the device end; user requests in, read data out.
  Assumes a short lock count and a word model kept by the bench.
*/
`timescale 1ns/10ps
module ddr_cio_burst2_sram_port_bench;
  localparam int AW = dcbsp_pkg::ADDR_W;
  localparam int DW = dcbsp_pkg::DATA_W;
  localparam int NB = DW / dcbsp_pkg::BYTE_W;
  localparam int LOCK = 8;
  logic i_ref_clk, i_rst_n, i_dll_enable, i_req_valid, i_req_write;
  logic [AW-1:0] i_req_addr;
  logic [DW-1:0] i_req_data0, i_req_data1, o_rd_data0, o_rd_data1;
  logic [NB-1:0] i_req_be_n0, i_req_be_n1;
  logic o_req_ready, o_rd_valid, o_dll_ready, o_dll_locked;
  int errors, checks_done, n;
  logic [DW-1:0] mm [logic [AW:0]];

  dcbsp_link_if #(.ADDR_W(AW), .DATA_W(DW)) link ();
  dcbsp_dev #(.ADDR_W(AW), .DATA_W(DW), .LOCK_CYCLES(LOCK)) dcbsp_dev_inst (
    .link(link.dev), .i_rst_n(i_rst_n), .o_dll_locked(o_dll_locked));
  dcbsp_host #(.ADDR_W(AW), .DATA_W(DW), .LOCK_CYCLES(LOCK)) dcbsp_host_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_dll_enable(i_dll_enable),
    .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
    .i_req_data0(i_req_data0), .i_req_data1(i_req_data1), .i_req_be_n0(i_req_be_n0),
    .i_req_be_n1(i_req_be_n1), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data0(o_rd_data0), .o_rd_data1(o_rd_data1), .o_dll_ready(o_dll_ready),
    .link(link.host));
  dcbsp_link_sva dcbsp_link_sva_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .k(link.k), .k_n(link.k_n),
    .load_n(link.load_n), .rw_sel(link.rw_sel), .dq_d_oe(link.dq_d_oe),
    .dq_h_oe(link.dq_h_oe), .echo_ref_pos(link.echo_ref_pos),
    .echo_ref_neg(link.echo_ref_neg), .read_valid_flag(link.read_valid_flag),
    .dll_off_n(link.dll_off_n));

  // Reference clock, 40 ns
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  task automatic give_verdict;
    $display("counts: errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Byte merge, low enable stores that byte
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, nw, input logic [NB-1:0] be);
    logic [DW-1:0] r;
    r = o;
    for (int i = 0; i < NB; i++) if (!be[i]) r[9*i +: 9] = nw[9*i +: 9];
    return r;
  endfunction

  // One burst-of-two request; reads check latency and both words
  task automatic op(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d0, d1,
                    input logic [NB-1:0] b0, b1, input int lat);
    int c;
    logic [AW:0] w0, w1;
    w0 = {a, 1'b0};
    w1 = {a, 1'b1};
    @(posedge i_ref_clk);
    i_req_valid <= 1'b1;
    i_req_write <= wr;
    i_req_addr <= a;
    i_req_data0 <= d0;
    i_req_data1 <= d1;
    i_req_be_n0 <= b0;
    i_req_be_n1 <= b1;
    c = 0;
    do begin
      @(negedge i_ref_clk);
      c++;
    end while (o_req_ready !== 1'b1 && c < 200);
    if (c >= 200) begin
      check(1'b0, "no ready");
      give_verdict();
    end
    @(posedge i_ref_clk);
    i_req_valid <= 1'b0;
    if (wr) begin
      mm[w0] = merge(mm.exists(w0) ? mm[w0] : 'x, d0, b0);
      mm[w1] = merge(mm.exists(w1) ? mm[w1] : 'x, d1, b1);
    end else begin
      c = 0;
      do begin
        @(posedge i_ref_clk);
        #1;
        c++;
      end while (o_rd_valid !== 1'b1 && c < 40);
      check(c == lat, "read latency");
      check(o_rd_data0 === mm[w0], "read word 0");
      check(o_rd_data1 === mm[w1], "read word 1");
    end
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    check(1'b0, "timeout");
    give_verdict();
  end

  initial begin
    {i_dll_enable, i_req_valid, i_req_write, i_req_addr} = '0;
    {i_req_data0, i_req_data1, i_req_be_n0, i_req_be_n1} = '0;
    errors = 0;
    checks_done = 0;
    i_rst_n = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    // Full write, then per-beat partial write, bypass read
    op(1'b1, 19'h0_0010, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0, 0);
    op(1'b1, 19'h0_0010, 36'hf_ffff_ffff, 36'he_eeee_eeee, 4'ha, 4'h5, 0);
    op(1'b0, 19'h0_0010, '0, '0, 4'hf, 4'hf, 10);
    $display("test byte writes done");
    // Three writes back to back, read newest first
    for (int i = 0; i < 3; i++) begin
      op(1'b1, 19'h0_0100 + 19'(i), 36'h0_a5a5_0000 + 36'(i), 36'h0_5a5a_0000 + 36'(i),
         4'h0, 4'h0, 0);
    end
    for (int i = 2; i >= 0; i--) op(1'b0, 19'h0_0100 + 19'(i), '0, '0, 4'hf, 4'hf, 10);
    $display("test coherency done");
    // Loop enable, lock wait, normal latency
    @(posedge i_ref_clk);
    i_dll_enable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end while (o_dll_ready !== 1'b1 && n < 400);
    check(n >= 4 * LOCK - 2 && n <= 4 * LOCK + 1, "lock time");
    // Device lock trails its two-flop bypass synchroniser
    n = 0;
    while (o_dll_locked !== 1'b1 && n < 16) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check(n > 0 && n < 16, "device lock");
    op(1'b0, 19'h0_0101, '0, '0, 4'hf, 4'hf, 16);
    op(1'b1, 19'h0_0200, 36'h3_c3c3_c3c3, 36'h0_0f0f_f0f0, 4'h3, 4'h0, 0);
    op(1'b0, 19'h0_0200, '0, '0, 4'hf, 4'hf, 16);
    $display("test loop mode done");
    // Bypass again drops lock
    @(posedge i_ref_clk);
    i_dll_enable <= 1'b0;
    repeat (20) @(posedge i_ref_clk);
    #1;
    check(o_dll_locked === 1'b0, "lock kept in bypass");
    check(o_dll_ready === 1'b0, "ready kept in bypass");
    op(1'b0, 19'h0_0200, '0, '0, 4'hf, 4'hf, 10);
    $display("test bypass return done");
    give_verdict();
  end
endmodule
